/* File: common/exec_latency_pkg.sv */
// Constants, opcode classes and timing lookup for the execution interlock.
// Assumes one pipeline clock; all counts are in pipeline clocks.
`default_nettype none

package exec_latency_pkg;

  // ------------------------------------------------------------
  // Widths and sizes
  // ------------------------------------------------------------
  localparam int DATA_W = 64;
  localparam int ADDR_W = 5;
  localparam int REG_COUNT = 32;
  localparam int CNT_W = 7;
  localparam int INT_LINES = 6;

  // ------------------------------------------------------------
  // Latency / repeat figures in pipeline clocks
  // ------------------------------------------------------------
  localparam logic [CNT_W-1:0] ONE_CYC = 7'h01;
  localparam logic [CNT_W-1:0] MULW_LAT = 7'h04;
  localparam logic [CNT_W-1:0] MULW_REP = 7'h03;
  localparam logic [CNT_W-1:0] MULD_LAT = 7'h06;
  localparam logic [CNT_W-1:0] MULD_REP = 7'h05;
  localparam logic [CNT_W-1:0] DIVW_LAT = 7'h24;
  localparam logic [CNT_W-1:0] DIVD_LAT = 7'h44;
  localparam logic [CNT_W-1:0] MACC_LAT = 7'h03;
  localparam logic [CNT_W-1:0] MACC_REP = 7'h02;
  localparam logic [CNT_W-1:0] MSUB_LAT = 7'h04;
  localparam logic [CNT_W-1:0] MSUB_REP = 7'h03;
  localparam logic [CNT_W-1:0] SLOW_EXTRA = 7'h01;
  localparam logic [CNT_W-1:0] FMUL_REPEAT = 7'h04;
  localparam logic [CNT_W-1:0] FDIV_REPEAT = 7'h0c;
  localparam logic [ADDR_W-1:0] ZERO_REG = 5'h00;

  // ------------------------------------------------------------
  // Instruction classes and modes
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_ALU, OP_LOAD, OP_STORE, OP_FP_LDST, OP_BRANCH, OP_JUMP,
    OP_WORD_MULTIPLY, OP_DOUBLEWORD_MULTIPLY, OP_WORD_DIVIDE,
    OP_DOUBLEWORD_DIVIDE, OP_MULTIPLY_ACCUMULATE, OP_MULTIPLY_SUBTRACT,
    OP_READ_PRODUCT, OP_WAIT
  } oth_op_e;

  typedef enum logic [1:0] {FP_ADD, FP_MUL, FP_DIVSQRT, FP_OTHER} fp_op_e;

  typedef enum logic [1:0] {PRIV_KERNEL, PRIV_SUPERVISOR, PRIV_USER} priv_e;

  // Latency (rep=0) or repeat (rep=1) of a multiply/divide class op
  function automatic logic [CNT_W-1:0] mdu_timing(input oth_op_e op, input logic slow,
                                                  input logic rep);
    logic [CNT_W-1:0] base;
    logic is_mult;
    base = ONE_CYC;
    is_mult = 1'b1;
    case (op)
      OP_WORD_MULTIPLY: base = rep ? MULW_REP : MULW_LAT;
      OP_DOUBLEWORD_MULTIPLY: base = rep ? MULD_REP : MULD_LAT;
      OP_MULTIPLY_ACCUMULATE: base = rep ? MACC_REP : MACC_LAT;
      OP_MULTIPLY_SUBTRACT: base = rep ? MSUB_REP : MSUB_LAT;
      OP_WORD_DIVIDE: begin
        base = DIVW_LAT;
        is_mult = 1'b0;
      end
      OP_DOUBLEWORD_DIVIDE: begin
        base = DIVD_LAT;
        is_mult = 1'b0;
      end
      default: is_mult = 1'b0;
    endcase
    return (slow && is_mult) ? CNT_W'(base + SLOW_EXTRA) : base;
  endfunction : mdu_timing

endpackage : exec_latency_pkg

`default_nettype wire

/* File: hdl/reg_file_32x64.sv */
// Thirty-two entry, 64-bit register array with two read ports, one write.
// Assumes writes come from the same pipeline clock; reads are combinational.
`default_nettype none

module reg_file_32x64 #(
  parameter bit HARD_ZERO = 1'b0
) (
  // Clock
  input wire logic clock_in,
  // Write port
  input wire logic wr_en_in,
  input wire logic [exec_latency_pkg::ADDR_W-1:0] wr_addr_in,
  input wire logic [exec_latency_pkg::DATA_W-1:0] wr_data_in,
  // Read ports
  input wire logic [exec_latency_pkg::ADDR_W-1:0] rd_a_addr_in,
  input wire logic [exec_latency_pkg::ADDR_W-1:0] rd_b_addr_in,
  output logic [exec_latency_pkg::DATA_W-1:0] rd_a_out,
  output logic [exec_latency_pkg::DATA_W-1:0] rd_b_out
);
  import exec_latency_pkg::*;

  logic [DATA_W-1:0] mem [REG_COUNT];

  // Entry zero of the integer file always reads zero
  wire wr_ok = wr_en_in && !(HARD_ZERO && wr_addr_in == ZERO_REG);

  always_ff @(posedge clock_in) begin
    if (wr_ok) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  assign rd_a_out = (HARD_ZERO && rd_a_addr_in == ZERO_REG) ? '0 : mem[rd_a_addr_in];
  assign rd_b_out = (HARD_ZERO && rd_b_addr_in == ZERO_REG) ? '0 : mem[rd_b_addr_in];

endmodule : reg_file_32x64

`default_nettype wire

/* File: hdl/op_timer.sv */
// Busy timer for one execution resource: loaded with a cycle count on issue.
// Assumes len_in is at least one; ready_out is high in the cycle the count ends.
`default_nettype none

module op_timer (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Start of an operation
  input wire logic load_in,
  input wire logic [exec_latency_pkg::CNT_W-1:0] len_in,
  // Resource free in this cycle
  output logic ready_out
);
  import exec_latency_pkg::*;

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic ready_r;
  logic ready_nxt;

  assign cnt_nxt = load_in ? CNT_W'(len_in - ONE_CYC) :
                   (cnt_r != '0) ? CNT_W'(cnt_r - ONE_CYC) : cnt_r;
  assign ready_nxt = load_in ? (len_in <= ONE_CYC) : (cnt_r <= ONE_CYC);

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      cnt_r <= '0;
      ready_r <= 1'b1;
    end else begin
      cnt_r <= cnt_nxt;
      ready_r <= ready_nxt;
    end
  end

  assign ready_out = ready_r;

endmodule : op_timer

`default_nettype wire

/* File: hdl/exec_latency_control.sv */
// Issue interlock, operand bypass, multiply/divide timing and standby control.
// Assumes the issue stage presents at most one instruction per class per clock
// and holds a refused instruction until it is taken.
`default_nettype none

module exec_latency_control (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Reset mode strap and interrupt pins (asynchronous)
  input wire logic slow_mult_strap_in,
  input wire logic [exec_latency_pkg::INT_LINES-1:0] int_req_in,
  input wire logic nmi_in,
  // Internal timer interrupt (same clock)
  input wire logic timer_irq_in,
  // Status register privilege bits
  input wire logic [1:0] ksu_in,
  input wire logic exl_in,
  input wire logic erl_in,
  // Other-class issue slot
  input wire logic oth_valid_in,
  input wire exec_latency_pkg::oth_op_e oth_op_in,
  input wire logic [exec_latency_pkg::ADDR_W-1:0] oth_src_a_in,
  input wire logic [exec_latency_pkg::ADDR_W-1:0] oth_src_b_in,
  input wire logic [exec_latency_pkg::ADDR_W-1:0] oth_dst_in,
  // Floating-point ALU issue slot
  input wire logic fp_valid_in,
  input wire exec_latency_pkg::fp_op_e fp_op_in,
  input wire logic [exec_latency_pkg::ADDR_W-1:0] fp_src_a_in,
  input wire logic [exec_latency_pkg::ADDR_W-1:0] fp_src_b_in,
  // Integer write-back
  input wire logic wb_en_in,
  input wire logic [exec_latency_pkg::ADDR_W-1:0] wb_dst_in,
  input wire logic [exec_latency_pkg::DATA_W-1:0] wb_data_in,
  // Floating-point write-back
  input wire logic fp_wb_en_in,
  input wire logic [exec_latency_pkg::ADDR_W-1:0] fp_wb_dst_in,
  input wire logic [exec_latency_pkg::DATA_W-1:0] fp_wb_data_in,
  // Issue results
  output logic oth_taken_out,
  output logic fp_taken_out,
  output logic stall_out,
  // Resource state
  output logic fmul_ready_out,
  output logic fdiv_ready_out,
  output logic mdu_ready_out,
  output logic prod_ready_out,
  output logic slow_mult_out,
  // Operands
  output logic [exec_latency_pkg::DATA_W-1:0] int_opa_out,
  output logic [exec_latency_pkg::DATA_W-1:0] int_opb_out,
  output logic [exec_latency_pkg::DATA_W-1:0] fp_opa_out,
  output logic [exec_latency_pkg::DATA_W-1:0] fp_opb_out,
  // Mode and power
  output exec_latency_pkg::priv_e priv_out,
  output logic standby_out,
  output logic clk_run_out
);
  import exec_latency_pkg::*;

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic strap_meta_r;
  logic strap_sync_r;
  logic slow_r;
  logic [INT_LINES-1:0] int_meta_r;
  logic [INT_LINES-1:0] int_sync_r;
  logic nmi_meta_r;
  logic nmi_sync_r;
  logic standby_r;
  logic standby_nxt;
  logic clk_run_r;
  logic br_block_r;
  logic ld_pend_r;
  logic [ADDR_W-1:0] ld_dst_r;
  logic oth_taken_r;
  logic fp_taken_r;
  logic stall_r;
  priv_e priv_r;
  priv_e priv_nxt;
  logic [DATA_W-1:0] int_opa_r;
  logic [DATA_W-1:0] int_opb_r;
  logic [DATA_W-1:0] fp_opa_r;
  logic [DATA_W-1:0] fp_opb_r;
  logic [DATA_W-1:0] int_rd_a;
  logic [DATA_W-1:0] int_rd_b;
  logic [DATA_W-1:0] fp_rd_a;
  logic [DATA_W-1:0] fp_rd_b;
  logic fmul_free;
  logic fdiv_free;
  logic mdu_free;
  logic prod_free;

  // Write data of this clock replaces the stale array value
  function automatic logic [DATA_W-1:0] bypass(input logic en, input logic [ADDR_W-1:0] dst,
                                               input logic [ADDR_W-1:0] src,
                                               input logic [DATA_W-1:0] wdata,
                                               input logic [DATA_W-1:0] rdata,
                                               input logic hard_zero);
    logic hit;
    hit = en && dst == src && !(hard_zero && src == ZERO_REG);
    return hit ? wdata : rdata;
  endfunction : bypass

  // ------------------------------------------------------------
  // Synchronisers and reset strap
  // ------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    strap_meta_r <= slow_mult_strap_in;
    strap_sync_r <= strap_meta_r;
    int_meta_r <= int_req_in;
    int_sync_r <= int_meta_r;
    nmi_meta_r <= nmi_in;
    nmi_sync_r <= nmi_meta_r;
  end

  // Strap sampled only while reset is held, frozen afterwards
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      slow_r <= strap_sync_r;
    end
  end

  // ------------------------------------------------------------
  // Register files
  // ------------------------------------------------------------
  reg_file_32x64 #(.HARD_ZERO(1'b1)) u_int_regs (
    .clock_in(clock_in),
    .wr_en_in(wb_en_in),
    .wr_addr_in(wb_dst_in),
    .wr_data_in(wb_data_in),
    .rd_a_addr_in(oth_src_a_in),
    .rd_b_addr_in(oth_src_b_in),
    .rd_a_out(int_rd_a),
    .rd_b_out(int_rd_b)
  );

  reg_file_32x64 #(.HARD_ZERO(1'b0)) u_fp_regs (
    .clock_in(clock_in),
    .wr_en_in(fp_wb_en_in),
    .wr_addr_in(fp_wb_dst_in),
    .wr_data_in(fp_wb_data_in),
    .rd_a_addr_in(fp_src_a_in),
    .rd_b_addr_in(fp_src_b_in),
    .rd_a_out(fp_rd_a),
    .rd_b_out(fp_rd_b)
  );

  // ------------------------------------------------------------
  // Issue decode
  // ------------------------------------------------------------
  wire is_mdu = oth_op_in inside {OP_WORD_MULTIPLY, OP_DOUBLEWORD_MULTIPLY,
                                  OP_WORD_DIVIDE, OP_DOUBLEWORD_DIVIDE,
                                  OP_MULTIPLY_ACCUMULATE, OP_MULTIPLY_SUBTRACT};
  wire is_ldst = oth_op_in inside {OP_LOAD, OP_STORE, OP_FP_LDST};
  wire is_brj = oth_op_in inside {OP_BRANCH, OP_JUMP};
  wire is_load = oth_op_in inside {OP_LOAD, OP_FP_LDST};
  // Load result is only usable two clocks after the load issued
  wire ld_hazard = ld_pend_r && ld_dst_r != ZERO_REG &&
                   (oth_src_a_in == ld_dst_r || oth_src_b_in == ld_dst_r);
  wire mdu_block = is_mdu && !mdu_free;
  wire prod_block = oth_op_in == OP_READ_PRODUCT && !prod_free;
  // Loads/stores and ALU ops see no resource limit of their own
  wire oth_ok = !standby_r && !br_block_r && !ld_hazard &&
                !mdu_block && !prod_block;
  wire oth_take = oth_valid_in && oth_ok;
  wire fp_busy = (fp_op_in == FP_MUL && !fmul_free) ||
                 (fp_op_in == FP_DIVSQRT && !fdiv_free);
  wire fp_ok = !standby_r && !fp_busy;
  wire fp_take = fp_valid_in && fp_ok;
  wire mdu_load = oth_take && is_mdu;
  wire fmul_load = fp_take && fp_op_in == FP_MUL;
  wire fdiv_load = fp_take && fp_op_in == FP_DIVSQRT;
  wire [CNT_W-1:0] mdu_rep_len = mdu_timing(oth_op_in, slow_r, 1'b1);
  wire [CNT_W-1:0] mdu_lat_len = mdu_timing(oth_op_in, slow_r, 1'b0);

  // ------------------------------------------------------------
  // Resource timers
  // ------------------------------------------------------------
  op_timer u_fmul_timer (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .load_in(fmul_load),
    .len_in(FMUL_REPEAT),
    .ready_out(fmul_free)
  );

  op_timer u_fdiv_timer (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .load_in(fdiv_load),
    .len_in(FDIV_REPEAT),
    .ready_out(fdiv_free)
  );

  op_timer u_mdu_rep_timer (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .load_in(mdu_load),
    .len_in(mdu_rep_len),
    .ready_out(mdu_free)
  );

  op_timer u_prod_lat_timer (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .load_in(mdu_load),
    .len_in(mdu_lat_len),
    .ready_out(prod_free)
  );

  // ------------------------------------------------------------
  // Standby and privilege
  // ------------------------------------------------------------
  wire wake = (|int_sync_r) || nmi_sync_r || timer_irq_in;
  assign standby_nxt = standby_r ? !wake : (oth_take && oth_op_in == OP_WAIT);

  always_comb begin
    priv_nxt = PRIV_USER;
    if (exl_in || erl_in || ksu_in == 2'h0) begin
      priv_nxt = PRIV_KERNEL;
    end else if (ksu_in == 2'h1) begin
      priv_nxt = PRIV_SUPERVISOR;
    end
  end

  // ------------------------------------------------------------
  // State registers
  // ------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      standby_r <= 1'b0;
      clk_run_r <= 1'b1;
      br_block_r <= 1'b0;
      ld_pend_r <= 1'b0;
      ld_dst_r <= ZERO_REG;
      oth_taken_r <= 1'b0;
      fp_taken_r <= 1'b0;
      stall_r <= 1'b0;
      priv_r <= PRIV_KERNEL;
    end else begin
      standby_r <= standby_nxt;
      clk_run_r <= !standby_nxt;
      br_block_r <= oth_take && is_brj;
      ld_pend_r <= oth_take && is_load;
      ld_dst_r <= oth_dst_in;
      oth_taken_r <= oth_take;
      fp_taken_r <= fp_take;
      stall_r <= (oth_valid_in && !oth_ok) || (fp_valid_in && !fp_ok);
      priv_r <= priv_nxt;
    end
  end

  // Operands carry the write of this clock forward
  always_ff @(posedge clock_in) begin
    int_opa_r <= bypass(wb_en_in, wb_dst_in, oth_src_a_in, wb_data_in, int_rd_a, 1'b1);
    int_opb_r <= bypass(wb_en_in, wb_dst_in, oth_src_b_in, wb_data_in, int_rd_b, 1'b1);
    fp_opa_r <= bypass(fp_wb_en_in, fp_wb_dst_in, fp_src_a_in, fp_wb_data_in, fp_rd_a, 1'b0);
    fp_opb_r <= bypass(fp_wb_en_in, fp_wb_dst_in, fp_src_b_in, fp_wb_data_in, fp_rd_b, 1'b0);
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign oth_taken_out = oth_taken_r;
  assign fp_taken_out = fp_taken_r;
  assign stall_out = stall_r;
  assign fmul_ready_out = fmul_free;
  assign fdiv_ready_out = fdiv_free;
  assign mdu_ready_out = mdu_free;
  assign prod_ready_out = prod_free;
  assign slow_mult_out = slow_r;
  assign int_opa_out = int_opa_r;
  assign int_opb_out = int_opb_r;
  assign fp_opa_out = fp_opa_r;
  assign fp_opb_out = fp_opb_r;
  assign priv_out = priv_r;
  assign standby_out = standby_r;
  assign clk_run_out = clk_run_r;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_fmul_spacing: assert property (
    @(posedge clock_in) disable iff (rst_in)
    fmul_load |=> (!fmul_load) [*3])
    else $error("FP multiply started within four clocks");

  a_fadd_overlap: assert property (
    @(posedge clock_in) disable iff (rst_in)
    fp_valid_in && fp_op_in == FP_ADD && !standby_r |-> fp_take)
    else $error("FP add held by busy multiplier");

  a_fpldst_rate: assert property (
    @(posedge clock_in) disable iff (rst_in)
    oth_take && oth_op_in == OP_FP_LDST ##1
    oth_valid_in && oth_op_in == OP_FP_LDST && !standby_r && !ld_hazard |-> oth_take)
    else $error("FP doubleword load/store not issued back to back");

  a_priv_kernel: assert property (
    @(posedge clock_in) disable iff (rst_in)
    (exl_in || erl_in) |=> priv_out == PRIV_KERNEL)
    else $error("Exception level did not select kernel mode");

  a_word_div_lat: assert property (
    @(posedge clock_in) disable iff (rst_in)
    mdu_load && oth_op_in == OP_WORD_DIVIDE |-> ##35 !prod_ready_out ##1 prod_ready_out)
    else $error("Word divide latency not 36 clocks");

  a_dword_div_lat: assert property (
    @(posedge clock_in) disable iff (rst_in)
    mdu_load && oth_op_in == OP_DOUBLEWORD_DIVIDE |-> ##67 !mdu_ready_out ##1 mdu_ready_out)
    else $error("Doubleword divide repeat not 68 clocks");

  a_branch_repeat: assert property (
    @(posedge clock_in) disable iff (rst_in)
    oth_take && is_brj |=> !oth_take)
    else $error("Instruction issued one clock after a branch or jump");

  a_slow_mult: assert property (
    @(posedge clock_in) disable iff (rst_in)
    mdu_load && oth_op_in == OP_WORD_MULTIPLY && slow_r |=> !mdu_free [*3])
    else $error("Slow word multiply repeat shorter than four clocks");

  a_ldst_b2b: assert property (
    @(posedge clock_in) disable iff (rst_in)
    oth_valid_in && is_ldst && !standby_r && !br_block_r && !ld_hazard |-> oth_take)
    else $error("Load or store stalled without a hazard");

  a_alu_bypass: assert property (
    @(posedge clock_in) disable iff (rst_in)
    wb_en_in && wb_dst_in == oth_src_a_in && oth_src_a_in != ZERO_REG
    |=> int_opa_out == $past(wb_data_in))
    else $error("ALU result not forwarded to operand A");

  a_prod_stall: assert property (
    @(posedge clock_in) disable iff (rst_in)
    oth_valid_in && oth_op_in == OP_READ_PRODUCT && !prod_free |-> !oth_take ##1 stall_out)
    else $error("Early product register read not stalled");

  a_fdiv_no_block: assert property (
    @(posedge clock_in) disable iff (rst_in)
    !fdiv_free && fp_valid_in && fp_op_in inside {FP_ADD, FP_OTHER} && !standby_r
    |-> fp_take)
    else $error("Divide/square root blocked another FP operation");

  a_standby_freeze: assert property (
    @(posedge clock_in) disable iff (rst_in)
    standby_r |-> !oth_take && !fp_take && !clk_run_out)
    else $error("Issue while in standby");

  a_standby_wake: assert property (
    @(posedge clock_in) disable iff (rst_in)
    standby_r && wake |=> !standby_out ##0 clk_run_out)
    else $error("Interrupt did not end standby");

  a_slow_const: assert property (
    @(posedge clock_in) disable iff (rst_in)
    !rst_in |=> $stable(slow_mult_out))
    else $error("Slow-multiply mode changed outside reset");

endmodule : exec_latency_control

`default_nettype wire

/* File: bench/issue_model.sv */
// Issue-stage model: presents one instruction and holds it until taken.
// Assumes each call starts just after a falling clock edge.
`default_nettype none

module issue_model (
  // Clock and answers
  input wire logic clock_in,
  input wire logic oth_taken_in,
  input wire logic fp_taken_in,
  // Requests
  output logic oth_valid_out,
  output exec_latency_pkg::oth_op_e oth_op_out,
  output logic fp_valid_out,
  output exec_latency_pkg::fp_op_e fp_op_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import exec_latency_pkg::*;

  initial begin
    oth_valid_out = 1'b0;
    fp_valid_out = 1'b0;
    oth_op_out = OP_ALU;
    fp_op_out = FP_ADD;
  end

  // Returns refused cycles, or -1 when not taken by the 199th falling edge
  // Valid stays up afterwards so back-to-back calls never pulse it low
  task automatic issue(input logic fp, input logic [3:0] op, output int n);
    n = 0;
    fp_op_out = fp_op_e'(op[1:0]);
    oth_op_out = oth_op_e'(op);
    if (fp_valid_out != fp) begin
      fp_valid_out = fp;
    end
    if (oth_valid_out == fp) begin
      oth_valid_out = !fp;
    end
    do begin
      @(negedge clock_in);
      n++;
    end while (!(fp ? fp_taken_in : oth_taken_in) && n < 200);
    n = (n < 200) ? n - 1 : -1;
  endtask : issue

  // Drops both slots; the next issue may follow with no edge between, as t_int does after t_fp
  task automatic idle();
    fp_valid_out = 1'b0;
    oth_valid_out = 1'b0;
  endtask : idle
endmodule : issue_model

`default_nettype wire

/* File: bench/tb.sv */
// Self-checking bench for the execution interlock.
// Assumes the issue model drives both slots; inputs change on falling edges.
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import exec_latency_pkg::*;
  logic clock_in = 1'b0, rst_in = 1'b1, strap = 1'b1, timer = 1'b0, exl = 1'b0;
  logic wb_en = 1'b0, fwb_en = 1'b0;
  logic [1:0] ksu = 2'h0;
  logic [4:0] sa = 5'h00, sb = 5'h00, dst = 5'h00, wdst = 5'h00, fsa = 5'h00;
  logic [63:0] wdat = 64'h0, fdat = 64'h0, opa, opb, fopa;
  logic ov, fv, ot, ft, stall, fmr, fdr, mdr, pdr, slow, sby, crun;
  oth_op_e oop;
  fp_op_e fop;
  priv_e priv;
  int err_count = 0, compares = 0, n, k;

  initial forever #10 clock_in = ~clock_in;

  exec_latency_control uut (.clock_in(clock_in), .rst_in(rst_in), .slow_mult_strap_in(strap),
    .int_req_in(6'h00), .nmi_in(1'b0), .timer_irq_in(timer), .ksu_in(ksu), .exl_in(exl),
    .erl_in(1'b0), .oth_valid_in(ov), .oth_op_in(oop), .oth_src_a_in(sa), .oth_src_b_in(sb),
    .oth_dst_in(dst), .fp_valid_in(fv), .fp_op_in(fop), .fp_src_a_in(fsa),
    .fp_src_b_in(5'h00), .wb_en_in(wb_en), .wb_dst_in(wdst), .wb_data_in(wdat),
    .fp_wb_en_in(fwb_en), .fp_wb_dst_in(wdst), .fp_wb_data_in(fdat), .oth_taken_out(ot),
    .fp_taken_out(ft), .stall_out(stall), .fmul_ready_out(fmr), .fdiv_ready_out(fdr),
    .mdu_ready_out(mdr), .prod_ready_out(pdr), .slow_mult_out(slow), .int_opa_out(opa),
    .int_opb_out(opb), .fp_opa_out(fopa), .fp_opb_out(), .priv_out(priv),
    .standby_out(sby), .clk_run_out(crun));

  issue_model pm (.clock_in(clock_in), .oth_taken_in(ot), .fp_taken_in(ft),
    .oth_valid_out(ov), .oth_op_out(oop), .fp_valid_out(fv), .fp_op_out(fop));

  // ----
  // Shared helpers
  // ----
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic ok, input string m);
    compares++;
    if (!ok) begin
      err_count++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask : chk

  // Issue and compare the refused-cycle count
  task automatic iss(input logic fp, input logic [3:0] op, input int exp);
    pm.issue(fp, op, n);
    if (n < 0) begin
      err_count++;
      report_and_stop();
    end
    chk(n == exp, "refused cycle count");
  endtask : iss

  task automatic wait_prod(input int exp);
    k = 1;
    while (pdr !== 1'b1 && k < 100) begin
      @(negedge clock_in);
      k++;
    end
    if (k >= 100) begin
      err_count++;
      report_and_stop();
    end
    chk(k == exp, "product latency");
  endtask : wait_prod

  // ----
  // Scenarios
  // ----
  task automatic t_reset();
    chk(slow === 1'b1, "strap not captured");
    chk({mdr, pdr, fmr, fdr} === 4'hf, "ready after reset");
    strap = 1'b0;
    $display("reset test done");
  endtask : t_reset

  // Slow mode stays on: strap was dropped after reset
  task automatic t_mdu();
    iss(1'b0, OP_WORD_MULTIPLY, 0);
    iss(1'b0, OP_ALU, 0);
    iss(1'b0, OP_READ_PRODUCT, 3);
    iss(1'b0, OP_WORD_DIVIDE, 0);
    pm.idle();
    wait_prod(36);
    iss(1'b0, OP_DOUBLEWORD_DIVIDE, 0);
    pm.idle();
    wait_prod(68);
    iss(1'b0, OP_DOUBLEWORD_MULTIPLY, 0);
    pm.idle();
    wait_prod(7);
    iss(1'b0, OP_MULTIPLY_ACCUMULATE, 0);
    pm.idle();
    wait_prod(4);
    iss(1'b0, OP_MULTIPLY_SUBTRACT, 0);
    pm.idle();
    wait_prod(5);
    $display("multiply/divide test done");
  endtask : t_mdu

  task automatic t_fp();
    iss(1'b1, FP_MUL, 0);
    iss(1'b1, FP_ADD, 0);
    iss(1'b1, FP_ADD, 0);
    iss(1'b1, FP_MUL, 1);
    iss(1'b1, FP_DIVSQRT, 0);
    iss(1'b1, FP_OTHER, 0);
    pm.idle();
    $display("floating-point test done");
  endtask : t_fp

  task automatic t_int();
    iss(1'b0, OP_LOAD, 0);
    iss(1'b0, OP_STORE, 0);
    iss(1'b0, OP_FP_LDST, 0);
    iss(1'b0, OP_FP_LDST, 0);
    dst = 5'h03;
    iss(1'b0, OP_ALU, 0);
    sa = 5'h03;
    iss(1'b0, OP_ALU, 0);
    iss(1'b0, OP_BRANCH, 0);
    iss(1'b0, OP_ALU, 1);
    iss(1'b0, OP_JUMP, 0);
    iss(1'b0, OP_ALU, 1);
    pm.idle();
    $display("integer issue test done");
  endtask : t_int

  // Same-edge write must reach the operand through the bypass
  task automatic t_opnd();
    {wb_en, fwb_en, wdst, sa, sb, fsa} = {2'b11, 5'h07, 5'h07, 5'h00, 5'h07};
    wdat = 64'h0123_4567_89ab_cdef;
    fdat = ~wdat;
    @(negedge clock_in);
    {wb_en, fwb_en} = 2'b00;
    chk(opa === wdat, "bypassed operand");
    chk(opb === 64'h0, "register zero");
    chk(fopa === fdat, "fp operand");
    @(negedge clock_in);
    chk(opa === wdat, "stored operand");
    $display("operand test done");
  endtask : t_opnd

  task automatic t_priv();
    ksu = 2'h2;
    @(negedge clock_in);
    chk(priv === PRIV_USER, "user mode");
    ksu = 2'h1;
    @(negedge clock_in);
    chk(priv === PRIV_SUPERVISOR, "supervisor mode");
    exl = 1'b1;
    @(negedge clock_in);
    chk(priv === PRIV_KERNEL, "kernel mode");
    $display("privilege test done");
  endtask : t_priv

  task automatic t_sby();
    iss(1'b0, OP_WAIT, 0);
    chk(sby === 1'b1 && crun === 1'b0, "standby entry");
    timer = 1'b1;
    @(negedge clock_in);
    timer = 1'b0;
    chk(sby === 1'b0 && crun === 1'b1, "standby exit");
    chk(stall === 1'b1, "held wait refused in standby");
    pm.idle();
    $display("standby test done");
  endtask : t_sby

  initial begin
    repeat (5) @(negedge clock_in);
    rst_in = 1'b0;
    t_reset();
    t_mdu();
    t_fp();
    t_int();
    t_opnd();
    t_priv();
    t_sby();
    report_and_stop();
  end
endmodule : tb

`default_nettype wire
